// ---- rtl/sci_host.sv ----
`include "sci_defs.svh"

// Overview of operation
// - Idle cycles drive chip select low with all strobes high.
// - Strobe levels encode activate, read, write, stop, precharge, refresh, mode load.
// - Mode load only with all banks idle, A12 low, then wait delay.
// - Activate opens a row in the selected bank until precharged.
// - Read uses column bits and precharge flag for auto precharge.
// - Write uses column bits and precharge flag for auto precharge.
// - Precharge closes one bank, or all when flag is high.
// - Bank usable only after precharge time; activate before access.
// - After auto precharge, wait precharge time before that bank.
// - Refresh with clock-gate high is auto refresh.
// - Precharge all banks and wait precharge time before refresh.
// - Issue refreshes spread evenly across the refresh period.
// - Clock-gate stays high for every issued command.
// - Mode word fields: length, type, latency, mode, write burst.
module sci_host
	import sci_pkg::*;
#(
	parameter int REF_INT = `SCI_REF_INT_CYC,
	parameter int TW      = 10
)(
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic                        sdCke,
	output logic                        sdCsN,
	output logic                        sdRasN,
	output logic                        sdCasN,
	output logic                        sdWeN,
	output logic [1:0]                  sdBankSelect,
	output logic [12:0]                 sdAddr,
	output logic [`SCI_DQ_W/8-1:0]      sdDqm,
	input  wire logic [`SCI_DQ_W-1:0]   sdDqIn,
	output logic [`SCI_DQ_W-1:0]        sdDqOut,
	output logic                        sdDqOeN
);
	localparam int DW = `SCI_DQ_W;
	localparam int MW = DW / 8;

	logic           awHeld, wHeld;
	logic [7:0]     awAddr;
	logic [31:0]    wWord;
	logic [3:0]     wStb;
	sci_op_t        cmdOp;
	logic           cmdFlag, cmdPend;
	logic [1:0]     cmdBank;
	logic [12:0]    addrReg;
	logic [DW-1:0]  wdat, rdat, dqS1, dqS2;
	logic [MW-1:0]  maskReg;
	logic           rdValid, errFlag, refDue, isRead;
	logic [11:0]    modeReg;
	sci_state_t     state;
	logic [TW-1:0]  el, endEl;
	logic [15:0]    refTmr;
	logic [3:0]     bankOpen, bankReady;
	logic [51:0]    rowOf;
	logic           issue, bad, take, issAp, issAll, cmdAccept;
	sci_op_t        next_op;
	logic [2:0]     next_pins;
	logic [12:0]    next_addr;
	logic [MW-1:0]  next_dqm;
	logic [TW-1:0]  next_load, next_end;
	logic [TW-1:0]  blBeats, rdEnd, wrEnd;
	logic [2:0]     cas;
	logic           fullPg, busy, commit, cmdWr, statWr;
	logic [32:0]    wrOld, rdWord;
	logic [31:0]    wMerged;

	// Register read mux; top bit flags a mapped offset
	function automatic logic [32:0] regRead(input logic [7:0] a);
		case (a)
			`SCI_REG_CMD:  regRead = {1'b1, 26'h0, cmdBank, cmdFlag, cmdOp};
			`SCI_REG_ADDR: regRead = {1'b1, 19'h0, addrReg};
			`SCI_REG_WLO:  regRead = {1'b1, wdat[31:0]};
			`SCI_REG_WHI:  regRead = {1'b1, wdat[63:32]};
			`SCI_REG_MASK: regRead = {1'b1, 24'h0, maskReg};
			`SCI_REG_RLO:  regRead = {1'b1, rdat[31:0]};
			`SCI_REG_RHI:  regRead = {1'b1, rdat[63:32]};
			`SCI_REG_STAT: regRead = {1'b1, 24'h0, bankOpen, refDue, errFlag, rdValid, busy};
			`SCI_REG_MODE: regRead = {1'b1, 20'h0, modeReg};
			`SCI_REG_ROW:  regRead = {1'b1, 19'h0, rowOf[cmdBank*13 +: 13]};
			default:       regRead = 33'h0;
		endcase
	endfunction

	// Byte-lane merge for partial writes
	function automatic logic [31:0] mergeBytes(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		mergeBytes = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				mergeBytes[b*8 +: 8] = n[b*8 +: 8];
			end
		end
	endfunction

	function automatic logic [2:0] opPins(input sci_op_t o);
		case (o)
			SCI_ACT: opPins = `SCI_PIN_ACT;
			SCI_RD:  opPins = `SCI_PIN_RD;
			SCI_WR:  opPins = `SCI_PIN_WR;
			SCI_PRE: opPins = `SCI_PIN_PRE;
			SCI_REF: opPins = `SCI_PIN_REF;
			SCI_MRS: opPins = `SCI_PIN_MRS;
			SCI_BST: opPins = `SCI_PIN_BST;
			default: opPins = `SCI_PIN_NOP;
		endcase
	endfunction

	// Bus handshakes and write decode
	assign s_axi_awready = ce && !awHeld;
	assign s_axi_wready  = ce && !wHeld;
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign commit        = awHeld && wHeld && !s_axi_bvalid;
	// Register read values, refreshed on any register change
	always_comb begin
		wrOld  = regRead(awAddr);
		rdWord = regRead(s_axi_araddr);
	end
	assign wMerged       = mergeBytes(wrOld[31:0], wWord, wStb);
	assign cmdWr         = commit && awAddr == `SCI_REG_CMD && wStb[0];
	assign statWr        = commit && awAddr == `SCI_REG_STAT && wStb[0];
	assign cmdAccept     = cmdWr && (!cmdPend || take);
	assign busy          = cmdPend || state != SCI_ST_IDLE;

	// Address and data capture, either order
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
			awAddr <= 8'h00;
			wWord  <= 32'h0;
			wStb   <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end else if (commit) begin
				awHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wWord <= s_axi_wdata;
				wStb  <= s_axi_wstrb;
			end else if (commit) begin
				wHeld <= 1'b0;
			end
		end
	end

	// Responses; unmapped offsets answer with slave error
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h0;
		end else if (ce) begin
			if (commit) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrOld[32] ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdWord[31:0];
				s_axi_rresp  <= rdWord[32] ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Software data registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addrReg <= 13'h0;
			wdat    <= '0;
			maskReg <= '0;
		end else if (ce && commit) begin
			case (awAddr)
				`SCI_REG_ADDR: addrReg <= wMerged[12:0];
				`SCI_REG_WLO:  wdat[31:0] <= wMerged;
				`SCI_REG_WHI:  wdat[63:32] <= wMerged;
				`SCI_REG_MASK: maskReg <= wMerged[MW-1:0];
				default: begin
				end
			endcase
		end
	end

	// Pending command; a write while one waits is refused unless that one is taken in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmdPend <= 1'b0;
			cmdOp   <= SCI_NOP;
			cmdFlag <= 1'b0;
			cmdBank <= 2'h0;
		end else if (ce) begin
			if (cmdAccept) begin
				cmdPend <= 1'b1;
				cmdOp   <= sci_op_t'(wMerged[2:0]);
				cmdFlag <= wMerged[3];
				cmdBank <= wMerged[5:4];
			end else if (take) begin
				cmdPend <= 1'b0;
			end
		end
	end

	// Sticky flags, write one to clear; a new event wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			errFlag <= 1'b0;
		end else if (ce) begin
			if (bad && take || cmdWr && !cmdAccept) begin
				errFlag <= 1'b1;
			end else if (statWr && wWord[`SCI_ST_ERR]) begin
				errFlag <= 1'b0;
			end
		end
	end

	assign cas     = modeReg[6:4];
	assign fullPg  = modeReg[2:0] == `SCI_FULL_CODE;
	always_comb begin
		case (modeReg[2:0])
			3'h1:    blBeats = TW'(2);
			3'h2:    blBeats = TW'(4);
			3'h3:    blBeats = TW'(8);
			default: blBeats = TW'(1);
		endcase
	end
	assign rdEnd = TW'(cas) + (blBeats > TW'(2) ? blBeats : TW'(2));
	assign wrEnd = modeReg[9] ? TW'(1) : blBeats;

	// Command selection: refresh first, then software
	always_comb begin
		issue   = 1'b0;
		bad     = 1'b0;
		next_op = cmdOp;
		if (state == SCI_ST_IDLE) begin
			if (refDue) begin
				if (&bankReady) begin
					issue   = 1'b1;
					next_op = |bankOpen ? SCI_PRE : SCI_REF;
				end
			end else if (cmdPend) begin
				case (cmdOp)
					SCI_ACT: begin
						bad   = bankOpen[cmdBank];
						issue = !bad && bankReady[cmdBank];
					end
					SCI_RD, SCI_WR: begin
						bad   = !bankOpen[cmdBank];
						issue = !bad && bankReady[cmdBank];
					end
					SCI_PRE: issue = cmdFlag ? &bankReady : bankReady[cmdBank];
					// Mode load and refresh need idle banks
					SCI_REF, SCI_MRS: begin
						bad   = |bankOpen;
						issue = !bad && &bankReady;
					end
					default: issue = 1'b1;
				endcase
			end
		end
	end
	assign take   = state == SCI_ST_IDLE && !refDue && cmdPend && (issue || bad);
	// No auto precharge in full-page mode
	assign issAp  = cmdFlag && !fullPg;
	// Only precharge-all, refresh and mode load touch every bank
	assign issAll = refDue || (cmdFlag && next_op == SCI_PRE) || next_op == SCI_REF
		|| next_op == SCI_MRS;

	// Pin values and bank timer loads
	always_comb begin
		next_pins = `SCI_PIN_NOP;
		next_addr = sdAddr;
		next_dqm  = '1;
		next_load = '0;
		next_end  = (next_op == SCI_RD) ? rdEnd : wrEnd;
		if (issue) begin
			next_pins = opPins(next_op);
			case (next_op)
				SCI_ACT: begin
					next_addr = addrReg;
					next_load = TW'(`SCI_RCD_CYC);
				end
				SCI_RD, SCI_WR: begin
					next_addr = {2'h0, issAp, 1'b0, addrReg[8:0]};
					next_load = issAp ? next_end + TW'(`SCI_RP_CYC) : '0;
					if (next_op == SCI_WR || cas == 3'h2) begin
						next_dqm = maskReg;
					end
				end
				SCI_PRE: begin
					next_addr = {2'h0, issAll, 10'h0};
					next_load = TW'(`SCI_RP_CYC);
				end
				SCI_REF: begin
					next_addr = 13'h0;
					next_load = TW'(`SCI_RC_CYC);
				end
				SCI_MRS: begin
					next_addr = {1'b0, addrReg[11:0]};
					next_load = TW'(`SCI_T_MRD_CYC);
				end
				default: begin
				end
			endcase
		end else if (state == SCI_ST_WAIT) begin
			// Cut full-page bursts after one beat
			if (fullPg && el == '0) begin
				next_pins = `SCI_PIN_BST;
			end
			// Read mask two clocks before data
			if (isRead && el + 1'b1 == TW'(cas) - TW'(2)) begin
				next_dqm = maskReg;
			end
		end
	end

	// Registered pins; inhibit only during reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sdCke        <= 1'b1;
			sdCsN        <= 1'b1;
			{sdRasN, sdCasN, sdWeN} <= `SCI_PIN_NOP;
			sdBankSelect <= 2'h0;
			sdAddr       <= 13'h0;
			sdDqm        <= '1;
			sdDqOut      <= '0;
			sdDqOeN      <= 1'b1;
		end else if (ce) begin
			sdCke        <= 1'b1;
			sdCsN        <= 1'b0;
			{sdRasN, sdCasN, sdWeN} <= next_pins;
			sdAddr       <= next_addr;
			sdDqm        <= next_dqm;
			sdDqOeN      <= !(issue && next_op == SCI_WR);
			if (issue) begin
				sdBankSelect <= cmdBank;
				sdDqOut      <= wdat;
			end
		end
	end

	// Burst sequencer and mode shadow
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state   <= SCI_ST_IDLE;
			el      <= '0;
			endEl   <= '0;
			isRead  <= 1'b0;
			modeReg <= `SCI_MODE_RST;
		end else if (ce) begin
			case (state)
				SCI_ST_IDLE: begin
					if (issue && (next_op == SCI_RD || next_op == SCI_WR)) begin
						state  <= SCI_ST_WAIT;
						el     <= '0;
						endEl  <= next_end;
						isRead <= next_op == SCI_RD;
					end
					if (issue && next_op == SCI_MRS) begin
						modeReg <= addrReg[11:0];
					end
				end
				SCI_ST_WAIT: begin
					el <= el + 1'b1;
					if (el == endEl) begin
						state <= SCI_ST_IDLE;
					end
				end
				default: state <= SCI_ST_IDLE;
			endcase
		end
	end

	// Read data sync and capture
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dqS1    <= '0;
			dqS2    <= '0;
			rdat    <= '0;
			rdValid <= 1'b0;
		end else if (ce) begin
			dqS1 <= sdDqIn;
			dqS2 <= dqS1;
			// First beat sampled at edge n+m
			if (state == SCI_ST_WAIT && isRead && el == TW'(cas) + TW'(2)) begin
				rdat    <= dqS2;
				rdValid <= 1'b1;
			end else if (statWr && wWord[`SCI_ST_RDV]) begin
				rdValid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			refTmr <= 16'h0;
			refDue <= 1'b0;
		end else if (ce) begin
			if (refTmr == 16'(REF_INT - 1)) begin
				refTmr <= 16'h0;
				refDue <= 1'b1;
			end else begin
				refTmr <= refTmr + 16'h1;
				if (issue && next_op == SCI_REF) begin
					refDue <= 1'b0;
				end
			end
		end
	end

	sci_bank_tracker #(
		.NB (4),
		.TW (TW),
		.RW (13)
	) u_banks (
		.core_clk  (core_clk),
		.rst       (rst),
		.ce        (ce),
		.issue     (issue),
		.op        (next_op),
		.bank      (cmdBank),
		.allFlag   (issAll),
		.apFlag    (issAp),
		.row       (addrReg),
		.loadCnt   (next_load),
		.bankOpen  (bankOpen),
		.bankReady (bankReady),
		.rowOf     (rowOf)
	);

	// Checks on the pin sequence
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst || !ce);
	sequence sPins(logic [2:0] c);
		!sdCsN && {sdRasN, sdCasN, sdWeN} == c;
	endsequence

	a_cke_with_cmd: assert property (!sdCsN |-> sdCke)
		else $error("clock-gate low with a command");
	a_mode_all_idle: assert property (issue && next_op == SCI_MRS |-> !(|bankOpen)
		##1 sPins(`SCI_PIN_MRS) ##0 !sdAddr[12]) else $error("mode load while bank open");
	a_mode_load_gap: assert property (sPins(`SCI_PIN_MRS) |=> sPins(`SCI_PIN_NOP))
		else $error("command inside mode-load delay");
	a_act_idle_bank: assert property (issue && next_op == SCI_ACT |->
		!bankOpen[cmdBank] ##1 sPins(`SCI_PIN_ACT) ##0 sdAddr == $past(addrReg))
		else $error("activate on open bank");
	a_rw_open_bank: assert property (!sdCsN && sdRasN && !sdCasN |->
		|($past(bankOpen) & (4'h1 << sdBankSelect))) else $error("access to idle bank");
	a_ref_all_idle: assert property (sPins(`SCI_PIN_REF) |-> !(|bankOpen))
		else $error("refresh with open bank");
	a_ref_served: assert property ($rose(refDue) |-> ##[1:100] sPins(`SCI_PIN_REF))
		else $error("refresh request not served");
	a_write_mask: assert property (sPins(`SCI_PIN_WR) |-> !sdDqOeN
		&& sdDqm == $past(maskReg) ##1 sdDqOeN) else $error("write mask or data wrong");
	a_full_page_stop: assert property (sPins(`SCI_PIN_RD) ##0 fullPg |->
		!sdAddr[10] ##1 sPins(`SCI_PIN_BST)) else $error("full-page burst not stopped");
endmodule

// ---- pkg/sci_defs.svh ----
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

// Clock and device timing
`define SCI_CLK_NS      20
`define SCI_T_RP_NS     20
`define SCI_T_RCD_NS    20
`define SCI_T_RC_NS     70
`define SCI_T_MRD_CYC   2
`define SCI_T_REF_MS    64
`define SCI_REF_CMDS    8192
`define SCI_RP_CYC      ((`SCI_T_RP_NS + `SCI_CLK_NS - 1) / `SCI_CLK_NS)
`define SCI_RCD_CYC     ((`SCI_T_RCD_NS + `SCI_CLK_NS - 1) / `SCI_CLK_NS)
`define SCI_RC_CYC      ((`SCI_T_RC_NS + `SCI_CLK_NS - 1) / `SCI_CLK_NS)
`define SCI_REF_INT_CYC ((`SCI_T_REF_MS * 1000000 / `SCI_REF_CMDS) / `SCI_CLK_NS)

// Data path
`define SCI_DQ_W        64
`define SCI_FULL_CODE   3'h7

// Register byte offsets
`define SCI_REG_CMD     8'h00
`define SCI_REG_ADDR    8'h04
`define SCI_REG_WLO     8'h08
`define SCI_REG_WHI     8'h0C
`define SCI_REG_MASK    8'h10
`define SCI_REG_RLO     8'h14
`define SCI_REG_RHI     8'h18
`define SCI_REG_STAT    8'h1C
`define SCI_REG_MODE    8'h20
`define SCI_REG_ROW     8'h24

// Status bits and mode reset value
`define SCI_ST_RDV      1
`define SCI_ST_ERR      2
`define SCI_MODE_RST    12'h020

// Strobe codes {row, column, write}
`define SCI_PIN_NOP     3'h7
`define SCI_PIN_ACT     3'h3
`define SCI_PIN_RD      3'h5
`define SCI_PIN_WR      3'h4
`define SCI_PIN_BST     3'h6
`define SCI_PIN_PRE     3'h2
`define SCI_PIN_REF     3'h1
`define SCI_PIN_MRS     3'h0

`endif

// ---- pkg/sci_pkg.sv ----
package sci_pkg;
	// Command codes written by software, in this order
	typedef enum logic [2:0] {
		SCI_NOP, SCI_ACT, SCI_RD, SCI_WR, SCI_PRE, SCI_REF, SCI_MRS, SCI_BST
	} sci_op_t;

	typedef enum logic {
		SCI_ST_IDLE, SCI_ST_WAIT
	} sci_state_t;
endpackage

// ---- rtl/sci_bank_tracker.sv ----
module sci_bank_tracker
	import sci_pkg::*;
#(
	parameter int NB = 4,
	parameter int TW = 10,
	parameter int RW = 13
)(
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic          ce,
	input  wire logic          issue,
	input  wire sci_op_t       op,
	input  wire logic [1:0]    bank,
	input  wire logic          allFlag,
	input  wire logic          apFlag,
	input  wire logic [RW-1:0] row,
	input  wire logic [TW-1:0] loadCnt,
	output logic [NB-1:0]      bankOpen,
	output logic [NB-1:0]      bankReady,
	output logic [NB*RW-1:0]   rowOf
);
	genvar i;
	generate
		for (i = 0; i < NB; i++) begin : g_bank
			logic [TW-1:0] tmr;
			logic [RW-1:0] rowQ;
			logic          hit;
			assign hit = issue && (allFlag || bank == 2'(i));
			// Open state, row and busy timer of one bank
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					bankOpen[i] <= 1'b0;
					tmr         <= '0;
					rowQ        <= '0;
				end else if (ce) begin
					if (hit) begin
						case (op)
							SCI_ACT: begin
								bankOpen[i] <= 1'b1;
								rowQ        <= row;
								tmr         <= loadCnt;
							end
							SCI_PRE, SCI_REF, SCI_MRS: begin
								bankOpen[i] <= 1'b0;
								tmr         <= loadCnt;
							end
							SCI_RD, SCI_WR: begin
								if (apFlag) begin
									bankOpen[i] <= 1'b0;
									tmr         <= loadCnt;
								end
							end
							default: begin
							end
						endcase
					end else if (tmr != '0) begin
						tmr <= tmr - 1'b1;
					end
				end
			end
			assign bankReady[i]        = (tmr == '0);
			assign rowOf[i*RW +: RW]   = rowQ;
		end
	endgenerate
endmodule

// ---- verification/sci_sd_model.sv ----
`include "sci_defs.svh"

module sci_sd_model #(
	parameter logic [63:0] BG = 64'hA5A5_A5A5_A5A5_A5A5
)(
	input  wire logic        core_clk,
	input  wire logic        sdCke,
	input  wire logic        sdCsN,
	input  wire logic        sdRasN,
	input  wire logic        sdCasN,
	input  wire logic        sdWeN,
	input  wire logic [1:0]  sdBankSelect,
	input  wire logic [12:0] sdAddr,
	input  wire logic [7:0]  sdDqm,
	input  wire logic [63:0] sdDqOut,
	input  wire logic        sdDqOeN,
	output logic [63:0]      sdDqIn,
	output int               viol
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  isOpen = '0;
	logic [11:0] mode   = `SCI_MODE_RST;  // Same as controller shadow
	logic [63:0] mem [int];
	logic [64:0] pipe [3] = '{default: '0};
	logic [7:0]  mq [2]   = '{default: '0};
	logic [63:0] w, last  = '0;
	int          key;

	initial viol = 0;

	// Command decode and bank state
	always @(posedge core_clk) begin
		key = int'({sdBankSelect, sdAddr[8:0]});
		w = mem.exists(key) ? mem[key] : BG;
		mq[0] <= sdDqm;
		mq[1] <= mq[0];
		last <= sdDqIn;
		pipe[0] <= pipe[1];
		pipe[1] <= pipe[2];
		pipe[2] <= '0;
		if (!sdCke) viol++;
		if (!sdCsN) case ({sdRasN, sdCasN, sdWeN})
		`SCI_PIN_ACT: begin
			if (isOpen[sdBankSelect]) viol++;
			isOpen[sdBankSelect] <= 1'b1;
		end
		`SCI_PIN_RD, `SCI_PIN_WR: begin
			if (!isOpen[sdBankSelect]) viol++;
			if (!sdWeN) begin
				if (sdDqOeN) viol++;
				for (int b = 0; b < 8; b++)
					if (!sdDqm[b]) w[b*8+:8] = sdDqOut[b*8+:8];
				mem[key] = w;
			end
			else pipe[mode[6:4]-1] <= {1'b1, w};
			if (sdAddr[10] && mode[2:0] != `SCI_FULL_CODE) isOpen[sdBankSelect] <= 1'b0;
		end
		`SCI_PIN_PRE: begin
			if (sdAddr[10]) isOpen <= '0;
			else isOpen[sdBankSelect] <= 1'b0;
		end
		`SCI_PIN_REF: if (isOpen != '0) viol++;
		`SCI_PIN_MRS: begin
			if (isOpen != '0 || sdAddr[12]) viol++;
			mode <= sdAddr[11:0];
		end
		default: ;
		endcase
	end

	always_comb
		for (int b = 0; b < 8; b++)
			sdDqIn[b*8+:8] = (pipe[0][64] && !mq[1][b]) ? pipe[0][b*8+:8] : ~last[b*8+:8];
endmodule

// ---- verification/tb_top.sv ----
`include "sci_defs.svh"
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin numErrors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top
	import sci_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0]  bk;
		logic [12:0] row;
		logic [8:0]  col;
		logic [7:0]  msk;
		logic        ap;
		logic [63:0] dat;
	} sci_row_t;
	localparam logic [63:0] BG = 64'hA5A5_A5A5_A5A5_A5A5;
	localparam int          RI = 300;
	logic        core_clk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, sdCke, sdCsN, sdRasN, sdCasN, sdWeN, sdDqOeN;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, sdDqm;
	logic [31:0] s_axi_wdata, s_axi_rdata, d0, d1, s;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sdBankSelect, r;
	logic [12:0] sdAddr;
	logic [63:0] sdDqIn, sdDqOut;
	int          viol, numErrors = 0, nChecks = 0, cyc = 0, refCnt = 0, bstCnt = 0;
	sci_row_t    rows [4] = '{
		'{2'd0, 13'h1FFF, 9'h000, 8'h00, 1'b0, 64'h0123_4567_89AB_CDEF},
		'{2'd1, 13'h0000, 9'h1FF, 8'h0F, 1'b1, 64'hFEDC_BA98_7654_3210},
		'{2'd2, 13'h0ABC, 9'h055, 8'hA5, 1'b0, 64'h1111_2222_3333_4444},
		'{2'd3, 13'h1555, 9'h100, 8'hFF, 1'b1, 64'h5555_6666_7777_8888}};

	sci_host #(.REF_INT(RI)) u_dut (.*);
	sci_sd_model #(.BG(BG)) u_mem (.*);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Refresh and stop counts on the pins
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (!sdCsN && {sdRasN, sdCasN, sdWeN} == `SCI_PIN_REF) refCnt <= refCnt + 1;
		if (!sdCsN && {sdRasN, sdCasN, sdWeN} == `SCI_PIN_BST) bstCnt <= bstCnt + 1;
	end

	function automatic logic [63:0] merged(logic [63:0] dt, logic [7:0] m);
		for (int b = 0; b < 8; b++) merged[b*8+:8] = m[b] ? BG[b*8+:8] : dt[b*8+:8];
	endfunction

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ta, tw, tk;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tk = s_axi_bvalid && s_axi_bready;
			rs = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		logic ta, tk;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tk = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic cmd(input sci_op_t op, input logic f, input logic [1:0] bk,
		input logic [12:0] ad);
		logic [31:0] st;
		axw(`SCI_REG_ADDR, {19'h0, ad}, r);
		axw(`SCI_REG_CMD, {26'h0, bk, f, op}, r);
		do axr(`SCI_REG_STAT, st); while (st[0]);
	endtask

	// Start just after a refresh so none closes a row under test
	task automatic waitRef();
		@(posedge core_clk iff (!sdCsN && {sdRasN, sdCasN, sdWeN} == `SCI_PIN_REF));
	endtask

	task automatic doRow(input sci_row_t cr, input logic expOpen);
		waitRef();
		cmd(SCI_ACT, 1'b0, cr.bk, cr.row);
		axr(`SCI_REG_ROW, d0);
		`CHK(d0[12:0], cr.row)
		axw(`SCI_REG_WLO, cr.dat[31:0], r);
		axw(`SCI_REG_WHI, cr.dat[63:32], r);
		axw(`SCI_REG_MASK, {24'h0, cr.msk}, r);
		cmd(SCI_WR, 1'b0, cr.bk, {4'h0, cr.col});
		axw(`SCI_REG_MASK, 32'h0, r);
		cmd(SCI_RD, cr.ap, cr.bk, {4'h0, cr.col});
		do axr(`SCI_REG_STAT, s); while (!s[`SCI_ST_RDV]);
		axw(`SCI_REG_STAT, 32'h2, r);
		axr(`SCI_REG_RLO, d0);
		axr(`SCI_REG_RHI, d1);
		`CHK({d1, d0}, merged(cr.dat, cr.msk))
		axr(`SCI_REG_STAT, s);
		`CHK(s[4+cr.bk], expOpen)
		if (expOpen) cmd(SCI_PRE, 1'b0, cr.bk, 13'h0);
	endtask

	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, over twenty times the expected run
	initial begin
		repeat (60000) @(posedge core_clk);
		numErrors++;
		tallyAndFinish();
	end

	// Main sequence
	initial begin
		{rst, ce, s_axi_wstrb} = 6'h3F;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		repeat (6) @(posedge core_clk);
		`CHK(sdCsN, 1'b1)
		rst <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		`CHK({sdCsN, sdRasN, sdCasN, sdWeN, sdCke}, 5'h0F)
		axr(`SCI_REG_MODE, d0);
		`CHK(d0[11:0], `SCI_MODE_RST)
		ce <= 1'b0;
		repeat (3) @(posedge core_clk);
		`CHK({s_axi_awready, s_axi_arready, sdCsN}, 3'h0)
		ce <= 1'b1;
		$display("reset test done");
		foreach (rows[i]) doRow(rows[i], !rows[i].ap);
		$display("row tests done");
		cmd(SCI_RD, 1'b0, 2'd3, 13'h0);
		axr(`SCI_REG_STAT, s);
		`CHK(s[`SCI_ST_ERR], 1'b1)
		axw(`SCI_REG_STAT, 32'h4, r);
		axr(`SCI_REG_STAT, s);
		`CHK(s[`SCI_ST_ERR], 1'b0)
		waitRef();
		cmd(SCI_ACT, 1'b0, 2'd0, 13'h10);
		cmd(SCI_ACT, 1'b0, 2'd2, 13'h20);
		cmd(SCI_MRS, 1'b0, 2'd0, 13'h030);
		axr(`SCI_REG_STAT, s);
		`CHK(s[`SCI_ST_ERR], 1'b1)
		axw(`SCI_REG_STAT, 32'h4, r);
		cmd(SCI_PRE, 1'b1, 2'd1, 13'h0);
		axr(`SCI_REG_STAT, s);
		`CHK(s[7:4], 4'h0)
		$display("refusal tests done");
		cmd(SCI_MRS, 1'b0, 2'd0, 13'h030);
		axr(`SCI_REG_MODE, d0);
		`CHK(d0[11:0], 12'h030)
		doRow(rows[0], 1'b1);
		cmd(SCI_MRS, 1'b0, 2'd0, 13'h027);
		doRow(rows[1], 1'b1);
		`CHK(bstCnt > 0, 1'b1)
		cmd(SCI_MRS, 1'b0, 2'd0, 13'h020);
		$display("mode tests done");
		axw(8'h40, 32'h1, r);
		`CHK(r, 2'b10)
		`CHK((refCnt + 2) * RI >= cyc, 1'b1)
		`CHK(viol, 0)
		$display("bus and refresh tests done");
		tallyAndFinish();
	end
endmodule
